// >>> verilog/ets_drive.sv
// Contract
// - Drive outputs lower-load direction each travel
// - Easiest choice: ignore command, go lower-load
// - Commanded choice: controller reads direction, commands (code commands wantDir; reads lower_load_dir_out only in easiest choice)
// - Evacuation speed never exceeds speed setting
// - Backup power draw capped by setting
// - Commanded choice: requested direction, level stop
// - Controller never closes both contactors
// - Controller: detect, fault, wait, open mains
// - Two seconds open-to-backup; backup asserts mode
// - Mode input: enter evacuation, clear fault
// - Ready, then permit, then speed/direction
// - Commanded mode: ignore speed, cap speed
// - Mode input drop: back to normal
// - Backup open, one second, then mains
//
// Drive end: evacuation mode, direction choice, speed and power caps
// Assumes the controller end keeps its contactor sequencing
// Limitation: only the commanded choice stops the car at floor level
// Mains stays failed through evacuation, so ready ignores it there
`timescale 1ns/100ps
module ets_drive #(
  parameter int SPEED_W = ets_pkg::SPEED_W,
  parameter int POWER_W = ets_pkg::POWER_W
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic clkEn,
  ets_link_if.drive link,
  input wire logic easiest_direction_choice,
  input wire logic [SPEED_W-1:0] evac_speed_setting,
  input wire logic [POWER_W-1:0] backup_power_cap_setting,
  input wire logic upsSupply,
  input wire logic mainsFail,
  input wire logic imbalanceValid,
  input wire logic carHeavier,
  input wire logic [POWER_W-1:0] powerDemand,
  input wire logic atFloorLevel,
  output logic evacMode,
  output logic motorRun,
  output logic motorDir,
  output logic [SPEED_W-1:0] motorSpeed,
  output logic [POWER_W-1:0] motorPower,
  output logic lowerLoadDir,
  output logic driveReady,
  output logic driveFault
);
  typedef enum logic [2:0] {
    ETS_NORMAL = 3'b001,
    ETS_EVAC = 3'b010,
    ETS_EVAC_STOP = 3'b100
  } ets_dstate_t;

  typedef struct packed {
    ets_dstate_t st;
    logic fault;
    logic lowDir;
    logic run;
    logic dir;
    logic [SPEED_W-1:0] speed;
    logic [POWER_W-1:0] power;
    logic evac;
    logic ready;
  } ets_drive_t;

  localparam ets_drive_t DRIVE_RESET = '{
    st: ETS_NORMAL,
    fault: 1'b0,
    lowDir: ets_pkg::DIR_DOWN,
    run: 1'b0,
    dir: ets_pkg::DIR_DOWN,
    speed: '0,
    power: '0,
    evac: 1'b0,
    ready: 1'b0
  };

  ets_drive_t r;
  ets_drive_t next_r;

  function automatic logic [SPEED_W-1:0] capSpeed(input logic [SPEED_W-1:0] v, input logic [SPEED_W-1:0] lim);
    if (v > lim) begin
      capSpeed = lim;
    end else begin
      capSpeed = v;
    end
  endfunction

  function automatic logic [POWER_W-1:0] capPower(input logic [POWER_W-1:0] p, input logic [POWER_W-1:0] lim);
    if (p > lim) begin
      capPower = lim;
    end else begin
      capPower = p;
    end
  endfunction

  // Car heavier pulls down; lower load follows gravity
  function automatic logic lowerLoadOf(input logic heavier);
    if (heavier) begin
      lowerLoadOf = ets_pkg::DIR_DOWN;
    end else begin
      lowerLoadOf = ets_pkg::DIR_UP;
    end
  endfunction

  function automatic logic inEvac(input ets_dstate_t st);
    if (st == ETS_NORMAL) begin
      inEvac = 1'b0;
    end else begin
      inEvac = 1'b1;
    end
  endfunction

  always_comb begin
    next_r = r;
    if (imbalanceValid) begin
      next_r.lowDir = lowerLoadOf(carHeavier);
    end
    // Fault only rises in normal mode; entering evacuation clears it
    if (mainsFail && r.st == ETS_NORMAL) begin
      next_r.fault = 1'b1;
    end
    next_r.run = 1'b0;
    next_r.speed = '0;
    next_r.power = '0;
    case (r.st)
      ETS_NORMAL: begin
        next_r.dir = link.dirCmd;
        if (link.runPermit && !r.fault) begin
          next_r.run = 1'b1;
          next_r.speed = link.speedCmd;
          next_r.power = powerDemand;
        end
        if (link.evac_mode_in) begin
          next_r.st = ETS_EVAC;
          next_r.fault = 1'b0;
        end
      end
      ETS_EVAC: begin
        if (easiest_direction_choice == ets_pkg::CHOICE_EASIEST) begin
          // Held for the whole travel so a load swing cannot reverse the car
          if (!r.run) begin
            next_r.dir = r.lowDir;
          end
        end else begin
          next_r.dir = link.dirCmd;
        end
        if (link.runPermit) begin
          next_r.run = 1'b1;
          // Speed command ignored in either choice
          next_r.speed = evac_speed_setting;
          if (upsSupply) begin
            next_r.power = capPower(powerDemand, backup_power_cap_setting);
          end else begin
            next_r.power = powerDemand;
          end
          // Only the commanded choice guarantees a level stop
          if (easiest_direction_choice == ets_pkg::CHOICE_COMMANDED && atFloorLevel && r.run) begin
            next_r.st = ETS_EVAC_STOP;
            next_r.run = 1'b0;
            next_r.speed = '0;
            next_r.power = '0;
          end
        end
        if (!link.evac_mode_in) begin
          next_r.st = ETS_NORMAL;
        end
      end
      ETS_EVAC_STOP: begin
        next_r.dir = r.dir;
        if (!link.runPermit) begin
          next_r.st = ETS_EVAC;
        end
        if (!link.evac_mode_in) begin
          next_r.st = ETS_NORMAL;
        end
      end
      default: begin
        next_r.st = ETS_NORMAL;
      end
    endcase
    next_r.speed = inEvac(r.st) ? capSpeed(next_r.speed, evac_speed_setting) : next_r.speed;
    // Status lands with the state change it reports
    next_r.evac = inEvac(next_r.st);
    next_r.ready = !next_r.fault && (!mainsFail || inEvac(next_r.st));
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      r <= DRIVE_RESET;
    end else if (clkEn) begin
      r <= next_r;
    end
  end

  assign evacMode = r.evac;
  assign driveReady = r.ready;
  assign driveFault = r.fault;
  assign motorRun = r.run;
  assign motorDir = r.dir;
  assign motorSpeed = r.speed;
  assign motorPower = r.power;
  assign lowerLoadDir = r.lowDir;
  assign link.lower_load_dir_out = r.lowDir;
  assign link.driveReady = r.ready;
  assign link.driveFault = r.fault;
endmodule

// >>> verilog/ets_pkg.sv
// Shared constants for the evacuation travel sequencer pair
// Assumes one 100 MHz clock shared by the drive end and the controller end
package ets_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int OPEN_TO_BACKUP_S = 2;
  localparam int BACKUP_TO_MAINS_S = 1;
  localparam int OPEN_TO_BACKUP_CYC = OPEN_TO_BACKUP_S * CLK_HZ;
  localparam int BACKUP_TO_MAINS_CYC = BACKUP_TO_MAINS_S * CLK_HZ;
  localparam int SPEED_W = 12;
  localparam int POWER_W = 16;
  localparam int CNT_W = 32;
  localparam logic DIR_UP = 1'h1;
  localparam logic DIR_DOWN = 1'h0;
  localparam logic CHOICE_EASIEST = 1'h0;
  localparam logic CHOICE_COMMANDED = 1'h1;
endpackage

// >>> verilog/ets_link_if.sv
// Wires between the lift controller and the drive
// Assumes both ends share clk and srst
`timescale 1ns/100ps
interface ets_link_if #(
  parameter int SPEED_W = ets_pkg::SPEED_W
);
  logic mains_contactor;
  logic backup_contactor;
  logic evac_mode_in;
  logic runPermit;
  logic [SPEED_W-1:0] speedCmd;
  logic dirCmd;
  logic driveReady;
  logic driveFault;
  logic lower_load_dir_out;
  modport drive (
    input mains_contactor, backup_contactor, evac_mode_in, runPermit, speedCmd, dirCmd,
    output driveReady, driveFault, lower_load_dir_out
  );
  modport ctrl (
    output mains_contactor, backup_contactor, evac_mode_in, runPermit, speedCmd, dirCmd,
    input driveReady, driveFault, lower_load_dir_out
  );
endinterface

// >>> verilog/ets_ctrl.sv
// Controller end: contactor interlock and evacuation sequencing
// Assumes the drive end answers with ready, fault and lower-load direction
`timescale 1ns/100ps
module ets_ctrl #(
  parameter int SPEED_W = ets_pkg::SPEED_W,
  parameter int CNT_W = ets_pkg::CNT_W,
  parameter int RESTORE_WAIT_CYC = 1000,
  parameter int OPEN_TO_BACKUP_CYC = ets_pkg::OPEN_TO_BACKUP_CYC,
  parameter int BACKUP_TO_MAINS_CYC = ets_pkg::BACKUP_TO_MAINS_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic clkEn,
  ets_link_if.ctrl link,
  input wire logic mainsFail,
  input wire logic commanded_direction_choice,
  input wire logic wantDir,
  input wire logic [SPEED_W-1:0] wantSpeed,
  input wire logic tripDone,
  output logic evacActive,
  output logic [2:0] seqState
);
  typedef enum logic [6:0] {
    ETS_C_MAINS = 7'b0000001,
    ETS_C_FAULTWAIT = 7'b0000010,
    ETS_C_RESTORE = 7'b0000100,
    ETS_C_GAP1 = 7'b0001000,
    ETS_C_READY = 7'b0010000,
    ETS_C_TRAVEL = 7'b0100000,
    ETS_C_GAP2 = 7'b1000000
  } ets_cstate_t;

  typedef struct packed {
    ets_cstate_t st;
    logic [CNT_W-1:0] cnt;
    logic mains;
    logic backup;
    logic permit;
    logic [SPEED_W-1:0] speed;
    logic dir;
    logic evac;
    logic [2:0] code;
  } ets_ctrl_t;

  ets_ctrl_t r;
  ets_ctrl_t next_r;

  function automatic logic expired(input logic [CNT_W-1:0] c, input int lim);
    expired = c >= CNT_W'(lim - 1);
  endfunction

  always_comb begin
    next_r = r;
    next_r.cnt = r.cnt + CNT_W'(1);
    case (r.st)
      ETS_C_MAINS: begin
        next_r.cnt = '0;
        if (mainsFail) begin
          next_r.st = ETS_C_FAULTWAIT;
        end
      end
      ETS_C_FAULTWAIT: begin
        next_r.cnt = '0;
        if (!mainsFail) begin
          next_r.st = ETS_C_MAINS;
        end else if (link.driveFault) begin
          next_r.st = ETS_C_RESTORE;
        end
      end
      ETS_C_RESTORE: begin
        if (!mainsFail) begin
          next_r.st = ETS_C_MAINS;
        end else if (expired(r.cnt, RESTORE_WAIT_CYC)) begin
          next_r.mains = 1'b0;
          next_r.st = ETS_C_GAP1;
          next_r.cnt = '0;
        end
      end
      ETS_C_GAP1: begin
        if (expired(r.cnt, OPEN_TO_BACKUP_CYC) && !r.mains) begin
          next_r.backup = 1'b1;
          next_r.st = ETS_C_READY;
        end
      end
      ETS_C_READY: begin
        if (link.driveReady && !link.driveFault) begin
          next_r.permit = 1'b1;
          next_r.st = ETS_C_TRAVEL;
        end
      end
      ETS_C_TRAVEL: begin
        // Commands follow permit by one cycle
        next_r.speed = wantSpeed;
        next_r.dir = (commanded_direction_choice == ets_pkg::CHOICE_COMMANDED) ? wantDir : link.lower_load_dir_out;
        if (tripDone) begin
          next_r.permit = 1'b0;
          next_r.speed = '0;
          next_r.backup = 1'b0;
          next_r.st = ETS_C_GAP2;
          next_r.cnt = '0;
        end
      end
      ETS_C_GAP2: begin
        if (expired(r.cnt, BACKUP_TO_MAINS_CYC) && !r.backup) begin
          next_r.mains = 1'b1;
          next_r.st = ETS_C_MAINS;
        end
      end
      default: begin
        next_r.st = ETS_C_MAINS;
      end
    endcase
    next_r.evac = next_r.backup;
    next_r.code = {next_r.st == ETS_C_TRAVEL, next_r.st == ETS_C_GAP1, next_r.st == ETS_C_FAULTWAIT};
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      r <= '{st: ETS_C_MAINS, cnt: '0, mains: 1'b1, backup: 1'b0, permit: 1'b0, speed: '0,
             dir: ets_pkg::DIR_DOWN, evac: 1'b0, code: 3'h0};
    end else if (clkEn) begin
      r <= next_r;
    end
  end

  assign evacActive = r.evac;
  assign seqState = r.code;
  assign link.mains_contactor = r.mains;
  assign link.backup_contactor = r.backup;
  assign link.evac_mode_in = r.backup;
  assign link.runPermit = r.permit;
  assign link.speedCmd = r.speed;
  assign link.dirCmd = r.dir;
endmodule

// >>> verification/ets_link_sva.sv
// Checker on the controller-drive link signals
// Assumes one clock domain, sync reset, instantiated beside the link
`timescale 1ns/100ps
module ets_link_sva #(
  parameter int SPEED_W = ets_pkg::SPEED_W,
  parameter int OPEN_TO_BACKUP_CYC = ets_pkg::OPEN_TO_BACKUP_CYC,
  parameter int BACKUP_TO_MAINS_CYC = ets_pkg::BACKUP_TO_MAINS_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic mains_contactor,
  input wire logic backup_contactor,
  input wire logic evac_mode_in,
  input wire logic runPermit,
  input wire logic [SPEED_W-1:0] speedCmd,
  input wire logic dirCmd,
  input wire logic driveReady,
  input wire logic driveFault,
  input wire logic lower_load_dir_out
);
  // Cycles with both contactors open; a counter keeps long gaps cheap
  logic [31:0] gapCnt;
  always_ff @(posedge clk) begin
    if (srst || mains_contactor || backup_contactor) begin
      gapCnt <= 32'h0;
    end else begin
      gapCnt <= gapCnt + 32'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  property p_interlock; !(mains_contactor && backup_contactor); endproperty
  property p_open_gap; $rose(backup_contactor) |-> gapCnt >= OPEN_TO_BACKUP_CYC; endproperty
  property p_restore_gap; $rose(mains_contactor) |-> gapCnt >= BACKUP_TO_MAINS_CYC; endproperty
  property p_mode_follows; evac_mode_in == backup_contactor; endproperty
  property p_fault_before_open; $fell(mains_contactor) |-> driveFault; endproperty
  property p_mode_clears; $rose(evac_mode_in) |=> !driveFault && driveReady; endproperty
  property p_permit_ready; $rose(runPermit) |-> $past(driveReady) && !driveFault; endproperty
  property p_cmd_after; $changed(speedCmd) && speedCmd != '0 |-> $past(runPermit); endproperty
  property p_release_order; $fell(backup_contactor) |-> !runPermit; endproperty
  a_interlock: assert property (p_interlock) else $error("both contactors closed");
  a_open_gap: assert property (p_open_gap) else $error("backup closed too soon");
  a_restore_gap: assert property (p_restore_gap) else $error("mains closed too soon");
  a_mode_follows: assert property (p_mode_follows) else $error("mode input not following backup");
  a_fault_before_open: assert property (p_fault_before_open) else $error("mains opened without fault");
  a_mode_clears: assert property (p_mode_clears) else $error("fault not cleared by mode");
  a_permit_ready: assert property (p_permit_ready) else $error("permit before ready");
  a_cmd_after: assert property (p_cmd_after) else $error("speed applied before permit");
  a_release_order: assert property (p_release_order) else $error("backup opened with permit");
  c_backup: cover property ($rose(backup_contactor));
  c_permit: cover property ($rose(runPermit));
  c_restore: cover property ($fell(backup_contactor) ##[1:200] $rose(mains_contactor));
endmodule

// >>> verification/evacuation_travel_sequencer_test.sv
// Bench for the sequencer pair: full evacuation trips in both choices
// Assumes shortened controller waits and a 100 MHz clock
`timescale 1ns/100ps
module evacuation_travel_sequencer_test;
  localparam int OB = 20;
  localparam int BM = 10;
  logic clk = 1'h0;
  logic srst = 1'h1;
  logic choice = 1'h0;
  logic ups = 1'h0;
  logic mainsFail = 1'h0;
  logic heavier = 1'h0;
  logic wantDir = 1'h0;
  logic tripDone = 1'h0;
  logic atFloor = 1'h0;
  logic [ets_pkg::SPEED_W-1:0] speedSet = 12'h0C8;
  logic [ets_pkg::SPEED_W-1:0] wantSpeed = 12'hFFF;
  logic [ets_pkg::POWER_W-1:0] powCap = 16'h0400;
  logic [ets_pkg::POWER_W-1:0] demand = 16'h0900;
  logic evacMode, motorRun, motorDir, lowerLoadDir;
  logic [ets_pkg::SPEED_W-1:0] motorSpeed;
  logic [ets_pkg::POWER_W-1:0] motorPower;
  logic evacActive;
  logic [2:0] seqState;
  int n_fail = 0;
  int n_checks = 0;
  ets_link_if link ();
  ets_drive ets_drive_i (.clk(clk), .srst(srst), .clkEn(1'h1), .link(link), .easiest_direction_choice(choice),
    .evac_speed_setting(speedSet), .backup_power_cap_setting(powCap), .upsSupply(ups), .mainsFail(mainsFail),
    .imbalanceValid(1'h1), .carHeavier(heavier), .powerDemand(demand), .atFloorLevel(atFloor),
    .evacMode(evacMode), .motorRun(motorRun), .motorDir(motorDir), .motorSpeed(motorSpeed),
    .motorPower(motorPower), .lowerLoadDir(lowerLoadDir), .driveReady(), .driveFault());
  ets_ctrl #(.RESTORE_WAIT_CYC(5), .OPEN_TO_BACKUP_CYC(OB), .BACKUP_TO_MAINS_CYC(BM)) ets_ctrl_i (.clk(clk),
    .srst(srst), .clkEn(1'h1), .link(link), .mainsFail(mainsFail), .commanded_direction_choice(choice),
    .wantDir(wantDir), .wantSpeed(wantSpeed), .tripDone(tripDone), .evacActive(evacActive), .seqState(seqState));
  ets_link_sva #(.OPEN_TO_BACKUP_CYC(OB), .BACKUP_TO_MAINS_CYC(BM)) ets_link_sva_i (.clk(clk), .srst(srst),
    .mains_contactor(link.mains_contactor), .backup_contactor(link.backup_contactor),
    .evac_mode_in(link.evac_mode_in), .runPermit(link.runPermit), .speedCmd(link.speedCmd), .dirCmd(link.dirCmd),
    .driveReady(link.driveReady), .driveFault(link.driveFault), .lower_load_dir_out(link.lower_load_dir_out));
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic final_report();
    if (n_fail == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic reset_check();
    cyc(3);
    chk("mains", link.mains_contactor, 1'h1);
    chk("backup", link.backup_contactor, 1'h0);
    chk("motorRun", motorRun, 1'h0);
  endtask
  // One whole trip: fail, wait, backup, travel, restore
  task automatic evac_trip(input logic ch, input logic hv, input logic up, input logic wd);
    int k;
    logic lowDir;
    lowDir = hv ? ets_pkg::DIR_DOWN : ets_pkg::DIR_UP;
    choice = ch;
    heavier = hv;
    ups = up;
    wantDir = wd;
    cyc(2);
    mainsFail = 1'h1;
    for (k = 0; k < 300 && evacMode !== 1'h1; k++) cyc(1);
    chk("mains", link.mains_contactor, 1'h0);
    chk("backup", link.backup_contactor, 1'h1);
    chk("fault", link.driveFault, 1'h0);
    chk("evacActive", evacActive, 1'h1);
    for (k = 0; k < 100 && motorRun !== 1'h1; k++) cyc(1);
    cyc(2);
    chk("seqState", seqState, 3'h4);
    chk("motorSpeed", motorSpeed, speedSet);
    chk("motorPower", motorPower, up ? powCap : demand);
    chk("lowerLoadDir", lowerLoadDir, lowDir);
    chk("lower_load_dir_out", link.lower_load_dir_out, lowDir);
    if (ch == ets_pkg::CHOICE_COMMANDED) begin
      chk("dirCmd", link.dirCmd, wd);
      chk("motorDir", motorDir, wd);
      atFloor = 1'h1;
      cyc(2);
      chk("motorRun", motorRun, 1'h0);
      atFloor = 1'h0;
    end else begin
      chk("motorDir", motorDir, lowDir);
    end
    tripDone = 1'h1;
    cyc(1);
    tripDone = 1'h0;
    mainsFail = 1'h0;
    for (k = 0; k < 100 && evacMode !== 1'h0; k++) cyc(1);
    chk("evacMode", evacMode, 1'h0);
    for (k = 0; k < 100 && link.mains_contactor !== 1'h1; k++) cyc(1);
    chk("backup", link.backup_contactor, 1'h0);
    chk("evacActive", evacActive, 1'h0);
    chk("mains", link.mains_contactor, 1'h1);
  endtask
  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (16) @(posedge clk);
    #1;
    srst = 1'h0;
    reset_check();
    evac_trip(ets_pkg::CHOICE_EASIEST, 1'h1, 1'h1, ets_pkg::DIR_UP);
    // Light car, command down: against the easy way on purpose
    evac_trip(ets_pkg::CHOICE_COMMANDED, 1'h0, 1'h0, ets_pkg::DIR_DOWN);
    final_report();
  end
  initial begin
    #50000;
    n_fail++;
    final_report();
  end
endmodule
